// ---- eewc_buf_if.sv ----
`timescale 1ns/1ps
// Page buffer access between the controller and its storage
interface eewc_buf_if;
  logic clr;
  logic we;
  logic [4:0] wr_idx;
  logic [7:0] wdata;
  logic [4:0] rd_idx;
  logic [7:0] rd_data;
  modport ctl (output clr, output we, output wr_idx, output wdata, output rd_idx,
               input rd_data);
  modport mem (input clr, input we, input wr_idx, input wdata, input rd_idx,
               output rd_data);
endinterface : eewc_buf_if

// ---- eewc_map.svh ----
`ifndef EEWC_MAP_SVH
`define EEWC_MAP_SVH
// ----------------------------------------------------------------------------
// Field layout of the control register
// ----------------------------------------------------------------------------
`define EEWC_CTL_W 5
`define EEWC_CTL_MODE 4
`define EEWC_CTL_WRITE_ENABLE_BIT 3
`define EEWC_CTL_WR 2
`define EEWC_CTL_READ_ENABLE_BIT 1
`define EEWC_CTL_RD 0
// ----------------------------------------------------------------------------
// Address, data and buffer geometry
// ----------------------------------------------------------------------------
`define EEWC_LOW_W 8
`define EEWC_HIGH_W 4
`define EEWC_ADDR_W 12
`define EEWC_IDX_W 5
`define EEWC_PAGE_BYTES 32
`define EEWC_PAGE_START 5'h00
`define EEWC_PAGE_LAST 5'h1f
`define EEWC_IDX_ONE 5'h01
// ----------------------------------------------------------------------------
// Reset values, bank select and write timer length
// ----------------------------------------------------------------------------
`define EEWC_BYTE_RST 8'h00
`define EEWC_HIGH_RST 4'h0
`define EEWC_BANK_RST 8'h00
`define EEWC_BANK_CTL 8'h01
`define EEWC_VALID_RST 32'h0000_0000
`define EEWC_TICK_W 8
`define EEWC_TICK_RST 8'h00
`define EEWC_TICK_ONE 8'h01
`define EEWC_WRITE_TICKS 8'h40
`endif

// ---- eewc_nvm_model.sv ----
`timescale 1ns/1ps
// Far side of the programming port: the cell array and its write timer
module eewc_nvm_model (
  // Clock
  input wire logic i_clk,
  // Array programming port
  input wire logic i_wr_strobe,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  // Write timer oscillator
  output logic o_osc
);
  logic [7:0] mem [0:4095];
  // ---------------------------------------------------------------------------
  // Timer runs free at a period unrelated to the system clock
  // ---------------------------------------------------------------------------
  // Half period above one clock period so the two-stage sync never misses a level
  initial begin
    o_osc = 1'b0;
    forever #65.3 o_osc = ~o_osc;
  end
  // Programmed bytes kept for read back
  always @(posedge i_clk) begin
    if (i_wr_strobe === 1'b1) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule : eewc_nvm_model

// ---- eewc_page_buf.sv ----
`timescale 1ns/1ps
`include "eewc_map.svh"
module eewc_page_buf (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Buffer port
  eewc_buf_if.mem bus
);
  logic [7:0] mem_r [`EEWC_PAGE_BYTES];
  logic [7:0] rd_data_r;

  // ---------------------------------------------------------------------------
  // Storage entries, cleared as a whole in one cycle
  // ---------------------------------------------------------------------------
  generate
    for (genvar g = 0; g < `EEWC_PAGE_BYTES; g++) begin : g_ent
      always_ff @(posedge i_clk) begin
        if (!i_rst_b || bus.clr) begin
          mem_r[g] <= `EEWC_BYTE_RST;
        end else if (bus.we && bus.wr_idx == 5'(g)) begin
          mem_r[g] <= bus.wdata;
        end
      end
    end
  endgenerate

  // Registered read port, one cycle of latency
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rd_data_r <= `EEWC_BYTE_RST;
    end else begin
      rd_data_r <= mem_r[bus.rd_idx];
    end
  end

  assign bus.rd_data = rd_data_r;
endmodule : eewc_page_buf

// ---- eewc_pkg.sv ----
package eewc_pkg;
  // Write sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TIMING,
    ST_COMMIT,
    ST_DONE
  } eewc_state_t;
endpackage : eewc_pkg

// ---- eewc_write_ctrl.sv ----
`timescale 1ns/1ps
`include "eewc_map.svh"
// Overview of operation
// - Mode bit low: write the data register byte to the addressed location.
// - Mode bit high: write the page buffer contents.
// - Write start is ignored unless write enable was already set.
// - Hardware clears write start when the write cycle ends.
// - Write cycle is timed by an asynchronous internal timer.
// - Page buffer holds 32 bytes and is cleared at reset.
// - Write enable falling clears the buffer; rising leaves it alone.
// - In page mode each loaded byte increments the low five address bits.
// - Low address stops at all ones; no roll over to page start.
// - After page write low five bits return to zero; page bits never increment.
// - Reset clears write enable.
// - Reset clears the bank pointer, hiding the control register.
// - Cycle end sets the EEPROM flag and the multi-function flag.
// - Vector only with global, EEPROM, multi-function enables set and stack free.
// - Servicing clears only the multi-function flag; software clears the other.
// - Mode select sits at bit four of the control register.
// - Address is twelve bits: high register bits 11..8 over the low byte.
module eewc_write_ctrl
  import eewc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Processor register writes
  input wire logic i_addr_low_we,
  input wire logic [7:0] i_addr_low_wdata,
  input wire logic i_addr_high_we,
  input wire logic [3:0] i_addr_high_wdata,
  input wire logic i_data_we,
  input wire logic [7:0] i_data_wdata,
  input wire logic i_ctrl_we,
  input wire logic [4:0] i_ctrl_wdata,
  input wire logic i_bank_we,
  input wire logic [7:0] i_bank_wdata,
  // Interrupt controller side
  input wire logic i_global_irq_enable,
  input wire logic i_eeprom_irq_enable,
  input wire logic i_mf_irq_enable,
  input wire logic i_stack_full,
  input wire logic i_irq_serviced,
  input wire logic i_eeprom_irq_flag_clr,
  // Write timer oscillator, asynchronous to i_clk
  input wire logic i_wtimer_osc,
  // Register read back
  output logic [7:0] o_addr_low_reg,
  output logic [3:0] o_addr_high_reg,
  output logic [7:0] o_eeprom_data_reg,
  output logic [4:0] o_eeprom_control_reg,
  output logic [7:0] o_bank_pointer,
  // Interrupt flags and vector request
  output logic o_eeprom_irq_flag,
  output logic o_mf_irq_flag,
  output logic o_irq_vector_req,
  // Array programming port
  output logic o_nvm_wr_strobe,
  output logic [11:0] o_nvm_addr,
  output logic [7:0] o_nvm_wdata
);
  eewc_state_t st_r;
  logic [7:0] addr_low_r;
  logic [3:0] addr_high_r;
  logic [7:0] data_r;
  logic mode_r, write_enable_bit_r, wr_r, read_enable_bit_r, rd_r;
  logic [7:0] bank_r;
  logic [31:0] valid_r;
  logic page_mode_r;
  logic [4:0] commit_idx_r, idx_d_r;
  logic pend_r;
  logic [7:0] tick_cnt_r;
  logic osc_s1_r, osc_s2_r, osc_s3_r;
  logic ctrl_acc, start, write_enable_bit_fall, buf_load, tick, done_page;

  eewc_buf_if buf_if ();

  // ---------------------------------------------------------------------------
  // Decode of processor accesses
  // ---------------------------------------------------------------------------
  // Control register is only reachable with bank one selected
  assign ctrl_acc = i_ctrl_we && bank_r == `EEWC_BANK_CTL;
  // Start needs write enable already set, not set by this same write
  assign start = ctrl_acc && !wr_r && write_enable_bit_r && i_ctrl_wdata[`EEWC_CTL_WR];
  assign write_enable_bit_fall = ctrl_acc && !wr_r && write_enable_bit_r && !i_ctrl_wdata[`EEWC_CTL_WRITE_ENABLE_BIT];
  assign buf_load = i_data_we && mode_r && !wr_r;
  assign done_page = st_r == ST_DONE && page_mode_r;

  // ---------------------------------------------------------------------------
  // Bank pointer and control bits
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bank_r <= `EEWC_BANK_RST;
    end else if (i_bank_we) begin
      bank_r <= i_bank_wdata;
    end
  end

  // Control writes are ignored while a cycle runs, so the buffer stays put
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      mode_r <= 1'b0;
      write_enable_bit_r <= 1'b0;
      read_enable_bit_r <= 1'b0;
      rd_r <= 1'b0;
    end else if (ctrl_acc && !wr_r) begin
      mode_r <= i_ctrl_wdata[`EEWC_CTL_MODE];
      write_enable_bit_r <= i_ctrl_wdata[`EEWC_CTL_WRITE_ENABLE_BIT];
      read_enable_bit_r <= i_ctrl_wdata[`EEWC_CTL_READ_ENABLE_BIT];
      rd_r <= i_ctrl_wdata[`EEWC_CTL_RD];
    end
  end

  // Write start: set by an accepted start, cleared when the cycle ends
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wr_r <= 1'b0;
    end else if (st_r == ST_DONE) begin
      wr_r <= 1'b0;
    end else if (start) begin
      wr_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Address and data registers
  // ---------------------------------------------------------------------------
  // Address is writable only in byte mode and while idle
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      addr_low_r <= `EEWC_BYTE_RST;
    end else if (done_page) begin
      addr_low_r[4:0] <= `EEWC_PAGE_START;
    end else if (i_addr_low_we && !mode_r && !wr_r) begin
      addr_low_r <= i_addr_low_wdata;
    end else if (buf_load && addr_low_r[4:0] != `EEWC_PAGE_LAST) begin
      addr_low_r[4:0] <= addr_low_r[4:0] + `EEWC_IDX_ONE;
    end
  end

  // Page select bits are only ever written by software
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      addr_high_r <= `EEWC_HIGH_RST;
    end else if (i_addr_high_we && !mode_r && !wr_r) begin
      addr_high_r <= i_addr_high_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      data_r <= `EEWC_BYTE_RST;
    end else if (i_data_we && !wr_r) begin
      data_r <= i_data_wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Page buffer: storage lives in its own module, fill marks kept here
  // ---------------------------------------------------------------------------
  assign buf_if.clr = write_enable_bit_fall;
  assign buf_if.we = buf_load;
  assign buf_if.wr_idx = addr_low_r[4:0];
  assign buf_if.wdata = i_data_wdata;
  assign buf_if.rd_idx = commit_idx_r;

  eewc_page_buf u_page_buf (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .bus(buf_if.mem)
  );

  // Only filled entries are programmed; marks drop after each page write
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      valid_r <= `EEWC_VALID_RST;
    end else if (write_enable_bit_fall || done_page) begin
      valid_r <= `EEWC_VALID_RST;
    end else if (buf_load) begin
      valid_r[addr_low_r[4:0]] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Write timer oscillator crossing
  // ---------------------------------------------------------------------------
  // Two stages before use; the third only serves the edge detector
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= i_wtimer_osc;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  assign tick = osc_s2_r && !osc_s3_r;

  // ---------------------------------------------------------------------------
  // Write sequencer
  // ---------------------------------------------------------------------------
  // Cycle length is set by timer ticks, so it floats against i_clk
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_r <= ST_IDLE;
      tick_cnt_r <= `EEWC_TICK_RST;
      page_mode_r <= 1'b0;
      commit_idx_r <= `EEWC_PAGE_START;
    end else begin
      case (st_r)
        ST_IDLE: begin
          tick_cnt_r <= `EEWC_TICK_RST;
          commit_idx_r <= `EEWC_PAGE_START;
          if (start) begin
            page_mode_r <= mode_r;
            st_r <= ST_TIMING;
          end
        end
        ST_TIMING: begin
          if (tick) begin
            tick_cnt_r <= tick_cnt_r + `EEWC_TICK_ONE;
            if (tick_cnt_r == `EEWC_WRITE_TICKS - `EEWC_TICK_ONE) begin
              st_r <= ST_COMMIT;
            end
          end
        end
        ST_COMMIT: begin
          if (!page_mode_r || commit_idx_r == `EEWC_PAGE_LAST) begin
            st_r <= ST_DONE;
          end else begin
            commit_idx_r <= commit_idx_r + `EEWC_IDX_ONE;
          end
        end
        ST_DONE: begin
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Read stage of the page walk, lines up with the buffer read latency
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pend_r <= 1'b0;
      idx_d_r <= `EEWC_PAGE_START;
    end else begin
      pend_r <= st_r == ST_COMMIT && page_mode_r && valid_r[commit_idx_r];
      idx_d_r <= commit_idx_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Array programming port
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_nvm_wr_strobe <= 1'b0;
      o_nvm_addr <= {`EEWC_HIGH_RST, `EEWC_BYTE_RST};
      o_nvm_wdata <= `EEWC_BYTE_RST;
    end else if (st_r == ST_COMMIT && !page_mode_r) begin
      o_nvm_wr_strobe <= 1'b1;
      o_nvm_addr <= {addr_high_r, addr_low_r};
      o_nvm_wdata <= data_r;
    end else if (pend_r) begin
      o_nvm_wr_strobe <= 1'b1;
      o_nvm_addr <= {addr_high_r, addr_low_r[7:5], idx_d_r};
      o_nvm_wdata <= buf_if.rd_data;
    end else begin
      o_nvm_wr_strobe <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt flags; a set in the same cycle as a clear wins
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_eeprom_irq_flag <= 1'b0;
      o_mf_irq_flag <= 1'b0;
    end else begin
      if (st_r == ST_DONE) begin
        o_eeprom_irq_flag <= 1'b1;
      end else if (i_eeprom_irq_flag_clr) begin
        o_eeprom_irq_flag <= 1'b0;
      end
      if (st_r == ST_DONE) begin
        o_mf_irq_flag <= 1'b1;
      end else if (i_irq_serviced) begin
        o_mf_irq_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_irq_vector_req <= 1'b0;
    end else begin
      o_irq_vector_req <= o_mf_irq_flag && o_eeprom_irq_flag && i_global_irq_enable &&
                          i_eeprom_irq_enable && i_mf_irq_enable && !i_stack_full &&
                          !i_irq_serviced;
    end
  end

  // Read back copies, all registered
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_addr_low_reg <= `EEWC_BYTE_RST;
      o_addr_high_reg <= `EEWC_HIGH_RST;
      o_eeprom_data_reg <= `EEWC_BYTE_RST;
      o_eeprom_control_reg <= '0;
      o_bank_pointer <= `EEWC_BANK_RST;
    end else begin
      o_addr_low_reg <= addr_low_r;
      o_addr_high_reg <= addr_high_r;
      o_eeprom_data_reg <= data_r;
      o_eeprom_control_reg <= {mode_r, write_enable_bit_r, wr_r, read_enable_bit_r, rd_r};
      o_bank_pointer <= bank_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_cycle_end;
    st_r == ST_DONE;
  endsequence
  sequence s_refused_start;
    ctrl_acc && !wr_r && !write_enable_bit_r && i_ctrl_wdata[`EEWC_CTL_WR];
  endsequence
  sequence s_byte_commit;
    st_r == ST_COMMIT && !page_mode_r;
  endsequence

  AST_START_NEEDS_WRITE_ENABLE_BIT: assert property (s_refused_start |=> !wr_r && st_r == ST_IDLE)
    else $error("write start accepted without write enable");
  AST_WR_CLEARED: assert property (s_cycle_end |=> !wr_r ##1 o_eeprom_control_reg[2] == 1'b0)
    else $error("write start not cleared at cycle end");
  AST_FLAGS_SET: assert property (s_cycle_end |=> o_eeprom_irq_flag && o_mf_irq_flag)
    else $error("interrupt flags not set at cycle end");
  AST_BYTE_WRITE: assert property (s_byte_commit |=> o_nvm_wr_strobe &&
                                   o_nvm_wdata == $past(data_r) &&
                                   o_nvm_addr == $past({addr_high_r, addr_low_r}))
    else $error("byte write did not program the data register");
  AST_PAGE_INC: assert property (buf_load && addr_low_r[4:0] != 5'h1f |=>
                                 addr_low_r[4:0] == $past(addr_low_r[4:0]) + 5'h01)
    else $error("low address not incremented after buffer load");
  AST_NO_ROLL: assert property (buf_load && addr_low_r[4:0] == 5'h1f |=>
                                addr_low_r[4:0] == 5'h1f)
    else $error("low address rolled over");
  AST_PAGE_RETURN: assert property (done_page |=> addr_low_r[4:0] == 5'h00 &&
                                    $stable(addr_high_r) && $stable(addr_low_r[7:5]))
    else $error("page address not returned to page start");
  AST_BUF_CLEAR: assert property (write_enable_bit_fall |=> valid_r == 32'h0 && !pend_r)
    else $error("buffer not cleared on write enable fall");
  AST_TIMER_HOLD: assert property (st_r == ST_TIMING && !tick |=> st_r == ST_TIMING)
    else $error("write cycle advanced without a timer tick");
  AST_VECTOR: assert property (o_irq_vector_req |-> $past(i_global_irq_enable) &&
                               $past(i_mf_irq_enable) && !$past(i_stack_full))
    else $error("vector requested without enables");
endmodule : eewc_write_ctrl

// ---- tb_eeprom_write_controller.sv ----
`timescale 1ns/1ps
`include "eewc_map.svh"
module tb_eeprom_write_controller import eewc_pkg::*;;
  localparam int k_low = 0;
  localparam int k_high = 1;
  localparam int k_data = 2;
  localparam int k_ctl = 3;
  localparam int k_bank = 4;
  localparam int k_svc = 5;
  localparam int k_fclr = 6;
  logic i_clk;
  logic i_rst_b;
  logic [6:0] we;
  logic [7:0] wd;
  logic gie, eie, mie, stk, osc;
  logic [7:0] rb_low, rb_data, rb_bank, ndata;
  logic [3:0] rb_high;
  logic [4:0] rb_ctl;
  logic f_ee, f_mf, vec, strobe;
  logic [11:0] naddr;
  logic [19:0] exp_q [$];
  logic [19:0] e;
  int bad_count = 0;
  int comparisons = 0;
  // ---------------------------------------------------------------------------
  // Design, far side and clock
  // ---------------------------------------------------------------------------
  eewc_write_ctrl u_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_addr_low_we(we[k_low]), .i_addr_low_wdata(wd),
    .i_addr_high_we(we[k_high]), .i_addr_high_wdata(wd[3:0]),
    .i_data_we(we[k_data]), .i_data_wdata(wd),
    .i_ctrl_we(we[k_ctl]), .i_ctrl_wdata(wd[4:0]),
    .i_bank_we(we[k_bank]), .i_bank_wdata(wd),
    .i_global_irq_enable(gie), .i_eeprom_irq_enable(eie), .i_mf_irq_enable(mie),
    .i_stack_full(stk), .i_irq_serviced(we[k_svc]), .i_eeprom_irq_flag_clr(we[k_fclr]),
    .i_wtimer_osc(osc),
    .o_addr_low_reg(rb_low), .o_addr_high_reg(rb_high), .o_eeprom_data_reg(rb_data),
    .o_eeprom_control_reg(rb_ctl), .o_bank_pointer(rb_bank),
    .o_eeprom_irq_flag(f_ee), .o_mf_irq_flag(f_mf), .o_irq_vector_req(vec),
    .o_nvm_wr_strobe(strobe), .o_nvm_addr(naddr), .o_nvm_wdata(ndata)
  );
  eewc_nvm_model u_nvm (.i_clk(i_clk), .i_wr_strobe(strobe), .i_addr(naddr),
    .i_wdata(ndata), .o_osc(osc));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // ---------------------------------------------------------------------------
  // Compare tasks and drivers
  // ---------------------------------------------------------------------------
  task automatic chk_val(input string nm, input logic [11:0] ex, input logic [11:0] got);
    comparisons++;
    if (got !== ex) begin
      $display("mismatch %s expected %h seen %h", nm, ex, got);
      bad_count++;
    end
  endtask : chk_val
  task automatic chk_nvm(input logic [19:0] ex, input logic [19:0] got);
    comparisons++;
    if (got !== ex) begin
      $display("mismatch nvm_write expected %h seen %h", ex, got);
      bad_count++;
    end
  endtask : chk_nvm
  task automatic final_report;
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // One-cycle strobe; a cycle passes before the next so no signal is set twice at once
  task automatic put(input int k, input logic [7:0] v);
    @(negedge i_clk);
    we[k] = 1'b1;
    wd = v;
    @(negedge i_clk);
    we[k] = 1'b0;
  endtask : put
  task automatic settle;
    repeat (2) @(negedge i_clk);
  endtask : settle
  // Start a write the way the program must, then poll the busy bit under a bound
  task automatic run_write(input logic mode);
    int n;
    gie = 1'b0;
    put(k_ctl, {3'h0, mode, 4'h8});
    // Write start is set alone, never together with read start
    put(k_ctl, {3'h0, mode, 4'hc});
    gie = 1'b1;
    n = 0;
    settle();
    // The core stays awake and keeps polling until the cycle is over
    while (rb_ctl[`EEWC_CTL_WR] !== 1'b0 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 2000) begin
      bad_count++;
      final_report();
    end
    chk_val("write_time", 12'h001, {11'h0, n > 100});
    chk_val("ctl_after", {7'h0, mode, 4'h8}, {7'h0, rb_ctl});
  endtask : run_write
  // Every programmed byte is taken against the oldest expected note
  always @(negedge i_clk) begin
    if (strobe === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : ~{naddr, ndata};
      chk_nvm(e, {naddr, ndata});
    end
  end
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [7:0] lo, hi, d;
    we = 7'h00;
    wd = 8'h00;
    gie = 1'b0;
    eie = 1'b0;
    mie = 1'b0;
    stk = 1'b0;
    i_rst_b = 1'b0;
    void'($urandom(32'h5f03c68e));
    repeat (6) @(negedge i_clk);
    i_rst_b = 1'b1;
    chk_val("ctl_rst", 12'h000, {7'h0, rb_ctl});
    chk_val("bank_rst", 12'h000, {4'h0, rb_bank});
    chk_val("addr_rst", 12'h000, {rb_high, rb_low});
    // Control register out of reach while bank is zero
    put(k_ctl, 8'h08);
    settle();
    chk_val("ctl_bank0", 12'h000, {7'h0, rb_ctl});
    put(k_bank, 8'h01);
    settle();
    chk_val("bank", 12'h001, {4'h0, rb_bank});
    // Start without enable is dropped
    put(k_ctl, 8'h04);
    settle();
    chk_val("ctl_noen", 12'h000, {7'h0, rb_ctl});
    // Byte write at a random address
    lo = 8'($urandom);
    hi = 8'($urandom & 32'hf);
    d = 8'($urandom);
    put(k_low, lo);
    put(k_high, hi);
    put(k_data, d);
    settle();
    chk_val("data_reg", {4'h0, d}, {4'h0, rb_data});
    exp_q.push_back({hi[3:0], lo, d});
    run_write(1'b0);
    chk_val("flags", 12'h003, {10'h0, f_ee, f_mf});
    chk_val("readback", {4'h0, d}, {4'h0, u_nvm.mem[{hi[3:0], lo}]});
    // Vector request needs all enables and a free stack
    eie = 1'b1;
    mie = 1'b1;
    stk = 1'b1;
    repeat (3) @(negedge i_clk);
    chk_val("vec_full", 12'h000, {11'h0, vec});
    stk = 1'b0;
    repeat (3) @(negedge i_clk);
    chk_val("vec", 12'h001, {11'h0, vec});
    put(k_svc, 8'h00);
    settle();
    chk_val("flags_svc", 12'h002, {10'h0, f_ee, f_mf});
    put(k_fclr, 8'h00);
    settle();
    chk_val("flags_clr", 12'h000, {10'h0, f_ee, f_mf});
    // Page fill from index 28: five bytes, the last two land on the end entry
    lo = 8'($urandom & 32'he0) | 8'h1c;
    put(k_low, lo);
    put(k_high, hi);
    put(k_ctl, 8'h10);
    for (int i = 0; i < 5; i++) begin
      d = 8'($urandom);
      put(k_data, d);
      if (i < 3) begin
        exp_q.push_back({hi[3:0], lo + 8'(i), d});
      end
      if (i == 1) begin
        settle();
        chk_val("low_inc", {4'h0, lo + 8'h02}, {4'h0, rb_low});
      end
    end
    exp_q.push_back({hi[3:0], lo | 8'h1f, d});
    put(k_low, 8'h00);
    settle();
    chk_val("low_stick", {4'h0, lo | 8'h1f}, {4'h0, rb_low});
    run_write(1'b1);
    chk_val("low_after", {hi[3:0], lo & 8'he0}, {rb_high, rb_low});
    // Enable falling empties the buffer: entry 0 loaded before it is not written
    put(k_data, 8'($urandom));
    put(k_ctl, 8'h10);
    d = 8'($urandom);
    put(k_data, d);
    exp_q.push_back({hi[3:0], (lo & 8'he0) | 8'h01, d});
    run_write(1'b1);
    settle();
    chk_val("left_over", 12'h000, 12'(exp_q.size()));
    final_report();
  end
endmodule : tb_eeprom_write_controller
